// *** hdl/oamu_top.sv ***
// holds the operand address mode unit: mode decode and address forming
// assumes a memory that answers a read with mem_rvalid_in some cycles later
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// [RL1] bits 2..0 register, 5..3 mode
// [RL2] autoinc/autodec step one byte, two word
// [RL3] byte register mode touches low byte only
// [RL4] index mode: register plus following word
// [RL5] mode 1: register is operand address
// [RL6] mode 3: read pointer, then add two
// [RL7] mode 5: subtract two, then read pointer
// [RL8] mode 7: register plus index, read pointer
// [RL9] each fetch through counter adds two
// [RL10] byte operand via counter still adds two
// [RL11] immediate: operand is word after instruction
// [RL12] absolute: following word is operand address
// [RL13] relative: extension plus updated counter
// [RL14] relative deferred: read word at that sum
// [RL15] source extension first, then destination
// [RL16] stack pointer always steps by two
// [RL17] two stack pointers, status selects one
// [RL18] source finishes before destination starts
module oamu_top #(
	parameter int unsigned word_w = oamu_pkg::oamu_word_w
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	// processor status word stack select
	input wire logic processor_status_word_sp_sel_in,
	// request: source then destination specifier
	input wire logic req_valid_in,
	output logic req_ready_out,
	input wire logic [5:0] src_spec_in,
	input wire logic [5:0] dst_spec_in,
	input wire logic has_src_in,
	input wire logic byte_op_in,
	// register write back for register mode
	input wire logic reg_wr_en_in,
	input wire logic [2:0] reg_wr_idx_in,
	input wire logic [word_w-1:0] reg_wr_data_in,
	input wire logic reg_wr_byte_in,
	// memory read port
	output logic mem_req_out,
	output logic [word_w-1:0] mem_addr_out,
	input wire logic mem_rvalid_in,
	input wire logic [word_w-1:0] mem_rdata_in,
	// results
	output logic res_valid_out,
	output logic res_is_src_out,
	output logic res_is_reg_out,
	output logic res_is_imm_out,
	output logic [2:0] res_reg_out,
	output logic [word_w-1:0] res_addr_out
);
	import oamu_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	oamu_state_type state_ff, nxt_state;
	logic cur_src_ff, nxt_cur_src;
	logic [5:0] spec_ff, nxt_spec;
	logic [5:0] dspec_ff;
	logic byte_ff;
	logic both_ff;
	logic mem_wait_ff, nxt_mem_wait;
	logic [word_w-1:0] addr_ff, nxt_addr;
	logic [word_w-1:0] mem_addr_ff, nxt_mem_addr;
	logic res_valid_ff, nxt_res_valid;
	logic res_imm_ff, nxt_res_imm;

	// ************************************************************
	// decode
	// ************************************************************
	logic [2:0] mode_w;
	logic [2:0] rsel_w;
	logic defer_w;
	logic is_pc_w;
	logic [word_w-1:0] rval_w;
	logic [word_w-1:0] pc_w;
	logic [word_w-1:0] step_w;
	logic rf_wr_en;
	logic rf_low;
	logic [2:0] rf_idx;
	logic [word_w-1:0] rf_data;

	assign rsel_w = spec_ff[oamu_reg_msb:oamu_reg_lsb]; // [RL1]
	assign mode_w = spec_ff[oamu_mode_msb:oamu_mode_lsb]; // [RL1]
	assign defer_w = spec_ff[oamu_defer_bit]; // [RL1]
	assign is_pc_w = (rsel_w == oamu_pc_idx);

	function automatic logic [15:0] step_of(input logic [2:0] r, input logic d, input logic b);
		if (d || r == oamu_sp_idx || r == oamu_pc_idx || !b) begin
			step_of = oamu_step_word; // [RL16] [RL10] [RL6] [RL7]
		end else begin
			step_of = oamu_step_byte; // [RL2]
		end
	endfunction : step_of

	assign step_w = step_of(rsel_w, defer_w, byte_ff);

	oamu_reg_file #(
		.word_w(word_w)
	) u_regs (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.sp_sel_in(processor_status_word_sp_sel_in),
		.rd_idx_in(rsel_w),
		.rd_data_out(rval_w),
		.wr_en_in(rf_wr_en),
		.wr_low_only_in(rf_low),
		.wr_idx_in(rf_idx),
		.wr_data_in(rf_data),
		.pc_out(pc_w)
	);

	// ************************************************************
	// sequencing
	// ************************************************************
	logic start_w;
	logic in_calc;
	logic step_now;
	logic upd_now;
	logic [word_w-1:0] upd_val;

	assign req_ready_out = (state_ff == oamu_st_idle);
	assign start_w = req_valid_in && req_ready_out;
	assign in_calc = (state_ff == oamu_st_rmw);
	// register update happens once on entry to calc
	assign step_now = in_calc && (mode_w == oamu_m_ainc || mode_w == oamu_m_aincdef || mode_w == oamu_m_adec
		|| mode_w == oamu_m_adecdef);
	assign upd_val = (mode_w[2]) ? rval_w - step_w : rval_w + step_w; // [RL2]
	// extension fetch through counter advances it by two
	assign upd_now = (state_ff == oamu_st_ext) && mem_rvalid_in && mem_wait_ff; // [RL9]
	assign rf_wr_en = step_now || upd_now || reg_wr_en_in;
	assign rf_idx = (step_now || upd_now) ? (upd_now ? oamu_pc_idx : rsel_w) : reg_wr_idx_in;
	assign rf_data = upd_now ? pc_w + oamu_step_word : (step_now ? upd_val : reg_wr_data_in);
	assign rf_low = !(step_now || upd_now) && reg_wr_byte_in; // [RL3]

	always_comb begin
		nxt_state = state_ff;
		nxt_cur_src = cur_src_ff;
		nxt_spec = spec_ff;
		nxt_mem_wait = mem_wait_ff;
		nxt_addr = addr_ff;
		nxt_mem_addr = mem_addr_ff;
		nxt_res_valid = 1'b0;
		nxt_res_imm = 1'b0;
		case (state_ff)
			oamu_st_idle: begin
				if (start_w) begin
					nxt_cur_src = has_src_in; // [RL15]
					nxt_spec = has_src_in ? src_spec_in : dst_spec_in;
					nxt_state = oamu_st_rmw;
				end
			end
			oamu_st_rmw: begin
				case (mode_w)
					oamu_m_reg: begin
						nxt_addr = {13'h0000, rsel_w};
						nxt_state = oamu_st_done;
					end
					oamu_m_regdef: begin
						nxt_addr = rval_w; // [RL5]
						nxt_state = oamu_st_done;
					end
					oamu_m_ainc: begin
						nxt_addr = rval_w;
						nxt_res_imm = is_pc_w; // [RL11]
						nxt_state = oamu_st_done;
					end
					oamu_m_aincdef: begin
						nxt_mem_addr = rval_w; // [RL6] [RL12]
						nxt_mem_wait = 1'b1;
						nxt_state = oamu_st_ptr;
					end
					oamu_m_adec: begin
						nxt_addr = upd_val;
						nxt_state = oamu_st_done;
					end
					oamu_m_adecdef: begin
						nxt_mem_addr = upd_val; // [RL7]
						nxt_mem_wait = 1'b1;
						nxt_state = oamu_st_ptr;
					end
					default: begin
						nxt_mem_addr = pc_w; // [RL4] [RL8] [RL15]
						nxt_mem_wait = 1'b1;
						nxt_state = oamu_st_ext;
					end
				endcase
			end
			oamu_st_ext: begin
				if (mem_rvalid_in) begin
					// counter value after its own fetch is the relative base
					nxt_addr = mem_rdata_in + (is_pc_w ? pc_w + oamu_step_word : rval_w); // [RL4] [RL13]
					if (mode_w == oamu_m_idxdef) begin
						nxt_mem_addr = nxt_addr; // [RL8] [RL14]
						nxt_mem_wait = 1'b1;
						nxt_state = oamu_st_ptr;
					end else begin
						nxt_mem_wait = 1'b0;
						nxt_state = oamu_st_done;
					end
				end
			end
			oamu_st_ptr: begin
				if (mem_rvalid_in) begin
					nxt_addr = mem_rdata_in; // [RL6] [RL12] [RL14]
					nxt_mem_wait = 1'b0;
					nxt_state = oamu_st_done;
				end
			end
			oamu_st_done: begin
				nxt_res_valid = 1'b1;
				nxt_res_imm = res_imm_ff;
				if (cur_src_ff && both_ff) begin
					nxt_cur_src = 1'b0; // [RL18]
					nxt_spec = dspec_ff;
					nxt_state = oamu_st_rmw;
				end else begin
					nxt_state = oamu_st_idle;
				end
			end
			default: begin
				nxt_state = oamu_st_idle;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			state_ff <= oamu_st_idle;
			cur_src_ff <= 1'b0;
			spec_ff <= 6'h00;
			dspec_ff <= 6'h00;
			byte_ff <= 1'b0;
			both_ff <= 1'b0;
			mem_wait_ff <= 1'b0;
			addr_ff <= oamu_reg_reset;
			mem_addr_ff <= oamu_reg_reset;
			res_valid_ff <= 1'b0;
			res_imm_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cur_src_ff <= nxt_cur_src;
			spec_ff <= nxt_spec;
			mem_wait_ff <= nxt_mem_wait;
			addr_ff <= nxt_addr;
			mem_addr_ff <= nxt_mem_addr;
			res_valid_ff <= nxt_res_valid;
			res_imm_ff <= (state_ff == oamu_st_rmw) ? nxt_res_imm : res_imm_ff;
			if (start_w) begin
				dspec_ff <= dst_spec_in;
				byte_ff <= byte_op_in;
				both_ff <= has_src_in;
			end
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	logic mem_req_w;
	logic [2:0] res_reg_ff;
	logic res_src_ff;
	logic res_isreg_ff;
	assign mem_req_w = (state_ff == oamu_st_ext || state_ff == oamu_st_ptr) && mem_wait_ff;
	assign mem_req_out = mem_req_w;
	assign mem_addr_out = mem_addr_ff;
	assign res_valid_out = res_valid_ff;
	assign res_is_imm_out = res_imm_ff && res_valid_ff;
	assign res_addr_out = addr_ff;
	assign res_reg_out = res_reg_ff;
	assign res_is_src_out = res_src_ff;
	assign res_is_reg_out = res_isreg_ff;

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			res_reg_ff <= 3'h0;
			res_src_ff <= 1'b0;
			res_isreg_ff <= 1'b0;
		end else if (state_ff == oamu_st_done) begin
			res_reg_ff <= rsel_w;
			res_src_ff <= cur_src_ff;
			res_isreg_ff <= (mode_w == oamu_m_reg);
		end
	end
endmodule : oamu_top
`default_nettype wire

// *** hdl/oamu_pkg.sv ***
// holds constants and types for the operand address mode unit
// assumes a 16-bit word and a byte-addressed memory
package oamu_pkg;
	localparam int unsigned oamu_word_w = 16;
	localparam int unsigned oamu_reg_count = 8;
	localparam logic [2:0] oamu_pc_idx = 3'h7;
	localparam logic [2:0] oamu_sp_idx = 3'h6;
	localparam logic [15:0] oamu_step_byte = 16'h0001;
	localparam logic [15:0] oamu_step_word = 16'h0002;
	localparam logic [15:0] oamu_reg_reset = 16'h0000;
	localparam logic [7:0] oamu_low_mask_w = 8'h00;
	localparam int unsigned oamu_reg_lsb = 0;
	localparam int unsigned oamu_reg_msb = 2;
	localparam int unsigned oamu_mode_lsb = 3;
	localparam int unsigned oamu_mode_msb = 5;
	localparam int unsigned oamu_defer_bit = 3;
	localparam logic [2:0] oamu_m_reg = 3'h0;
	localparam logic [2:0] oamu_m_regdef = 3'h1;
	localparam logic [2:0] oamu_m_ainc = 3'h2;
	localparam logic [2:0] oamu_m_aincdef = 3'h3;
	localparam logic [2:0] oamu_m_adec = 3'h4;
	localparam logic [2:0] oamu_m_adecdef = 3'h5;
	localparam logic [2:0] oamu_m_idx = 3'h6;
	localparam logic [2:0] oamu_m_idxdef = 3'h7;

	typedef enum logic [2:0] {
		oamu_st_idle = 3'b000,
		oamu_st_rmw = 3'b001,
		oamu_st_ext = 3'b011,
		oamu_st_ptr = 3'b111,
		oamu_st_done = 3'b101
	} oamu_state_type;
endpackage : oamu_pkg

// *** hdl/oamu_reg_file.sv ***
// holds the general register file with two stack pointers
// assumes one write port and two read ports, same clock
`timescale 1ns/100ps
`default_nettype none
module oamu_reg_file #(
	parameter int unsigned word_w = oamu_pkg::oamu_word_w
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	// stack select
	input wire logic sp_sel_in,
	// read port
	input wire logic [2:0] rd_idx_in,
	output logic [word_w-1:0] rd_data_out,
	// write port
	input wire logic wr_en_in,
	input wire logic wr_low_only_in,
	input wire logic [2:0] wr_idx_in,
	input wire logic [word_w-1:0] wr_data_in,
	// direct view of program counter
	output logic [word_w-1:0] pc_out
);
	import oamu_pkg::*;
	logic [word_w-1:0] regs_ff [0:oamu_reg_count-1];
	logic [word_w-1:0] alt_sp_ff;
	logic [word_w-1:0] cur_val;
	logic [word_w-1:0] merged;
	logic use_alt_rd;
	logic use_alt_wr;

	assign use_alt_rd = sp_sel_in && (rd_idx_in == oamu_sp_idx); // [RL17]
	assign use_alt_wr = sp_sel_in && (wr_idx_in == oamu_sp_idx); // [RL17]
	assign rd_data_out = use_alt_rd ? alt_sp_ff : regs_ff[rd_idx_in];
	assign pc_out = regs_ff[oamu_pc_idx];
	assign cur_val = use_alt_wr ? alt_sp_ff : regs_ff[wr_idx_in];
	assign merged = wr_low_only_in ? {cur_val[word_w-1:8], wr_data_in[7:0]} : wr_data_in; // [RL3]

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			for (int i = 0; i < oamu_reg_count; i++) begin
				regs_ff[i] <= oamu_reg_reset;
			end
			alt_sp_ff <= oamu_reg_reset;
		end else if (wr_en_in) begin
			if (use_alt_wr) begin
				alt_sp_ff <= merged;
			end else begin
				regs_ff[wr_idx_in] <= merged;
			end
		end
	end
endmodule : oamu_reg_file
`default_nettype wire

// *** verif/oamu_mem_model.sv ***
// memory model: answers each read lat_in+1 cycles after the request rises
// assumes one read outstanding; data is address plus 16'h0100
`timescale 1ns/100ps
`default_nettype none
// ********************
// memory model
// ********************
module oamu_mem_model (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	// read port
	input wire logic mem_req_in,
	input wire logic [15:0] mem_addr_in,
	input wire logic [3:0] lat_in,
	output logic mem_rvalid_out,
	output logic [15:0] mem_rdata_out
);
	logic [3:0] cnt_ff;
	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			mem_rvalid_out <= 1'b0;
			mem_rdata_out <= 16'h0000;
			cnt_ff <= 4'h0;
		end else if (mem_rvalid_out) begin
			// data no longer held after the pulse
			mem_rvalid_out <= 1'b0;
			mem_rdata_out <= ~mem_rdata_out;
			cnt_ff <= 4'h0;
		end else if (mem_req_in && cnt_ff >= lat_in) begin
			mem_rvalid_out <= 1'b1;
			mem_rdata_out <= mem_addr_in + 16'h0100;
		end else if (mem_req_in) begin
			cnt_ff <= cnt_ff + 4'h1;
		end
	end
endmodule : oamu_mem_model
`default_nettype wire

// *** verif/oamu_top_asserts.sv ***
// checker for oamu_top port timing
// assumes one clock, bound onto every oamu_top
`timescale 1ns/100ps
`default_nettype none
// ********************
// checker
// ********************
module oamu_top_asserts #(
	parameter int unsigned word_w = oamu_pkg::oamu_word_w
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	// request
	input wire logic req_valid_in,
	input wire logic req_ready_out,
	input wire logic [5:0] src_spec_in,
	input wire logic [5:0] dst_spec_in,
	input wire logic has_src_in,
	// memory
	input wire logic mem_req_out,
	input wire logic [word_w-1:0] mem_addr_out,
	input wire logic mem_rvalid_in,
	// results
	input wire logic res_valid_out,
	input wire logic res_is_src_out,
	input wire logic res_is_reg_out,
	input wire logic res_is_imm_out,
	input wire logic [2:0] res_reg_out,
	input wire logic [word_w-1:0] res_addr_out
);
	import oamu_pkg::*;
	wire logic take;
	assign take = req_valid_in && req_ready_out;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);
	a_reset_quiet: assert property ($past(reset_in) |-> !res_valid_out && !mem_req_out) else $error("busy after reset");
	a_mem_hold: assert property (mem_req_out && !mem_rvalid_in |=> mem_req_out && $stable(mem_addr_out))
		else $error("read dropped or moved");
	a_busy_ready: assert property (mem_req_out |-> !req_ready_out) else $error("ready while reading");
	a_reg_lat: assert property (take && !has_src_in && dst_spec_in[5:3] == 3'h0 |-> ##3
		res_valid_out && res_is_reg_out && res_reg_out == $past(dst_spec_in[2:0], 3)) else $error("register result");
	a_defer_lat: assert property (take && !has_src_in && dst_spec_in[5:3] == 3'h1 |-> ##[2:4]
		res_valid_out && !res_is_reg_out) else $error("deferred result late");
	a_src_first: assert property (take && has_src_in && src_spec_in[5:3] == 3'h0 && dst_spec_in[5:3] == 3'h0
		|-> ##3 (res_valid_out && res_is_src_out) ##[1:8] (res_valid_out && !res_is_src_out)) else $error("order");
	a_imm_flag: assert property (res_valid_out && res_is_imm_out |-> !res_is_reg_out) else $error("imm flag");
	a_reg_index: assert property (res_valid_out && res_is_reg_out |-> res_addr_out == word_w'(res_reg_out))
		else $error("register index");
endmodule : oamu_top_asserts
bind oamu_top oamu_top_asserts #(.word_w(word_w)) u_chk (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
	.req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .src_spec_in(src_spec_in),
	.dst_spec_in(dst_spec_in), .has_src_in(has_src_in), .mem_req_out(mem_req_out), .mem_addr_out(mem_addr_out),
	.mem_rvalid_in(mem_rvalid_in), .res_valid_out(res_valid_out), .res_is_src_out(res_is_src_out),
	.res_is_reg_out(res_is_reg_out), .res_is_imm_out(res_is_imm_out), .res_reg_out(res_reg_out),
	.res_addr_out(res_addr_out));
`default_nettype wire

// *** verif/oamu_top_tb.sv ***
// testbench for oamu_top with the memory model
// assumes memory data is address plus 16'h0100
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin failures++; $display("BAD %s exp %h got %h", n, e, s); end end
// ********************
// bench
// ********************
module oamu_top_tb;
	import oamu_pkg::*;
	logic clk_sys_in = 1'b0;
	logic reset_in = 1'b1;
	logic sel = 1'b0, req_valid_in = 1'b0, has_src_in = 1'b0, byte_op_in = 1'b0, reg_wr_en_in = 1'b0, wr_byte = 1'b0;
	logic [5:0] src_spec_in = 6'h00, dst_spec_in = 6'h00;
	logic [2:0] wr_idx = 3'h0;
	logic [15:0] wr_data = 16'h0000;
	logic [3:0] lat = 4'h0;
	wire logic req_ready_out, mem_req_out, mem_rvalid_in, res_valid_out, res_is_src_out, res_is_reg_out, res_is_imm_out;
	wire logic [2:0] res_reg_out;
	wire logic [15:0] mem_addr_out, mem_rdata_in, res_addr_out;
	logic [15:0] ra [2];
	logic rs [2], rg [2], ri [2];
	logic [2:0] rr [2];
	int nr = 0, cyc = 0, failures = 0, total_checks = 0;
	always #2 clk_sys_in = ~clk_sys_in;
	oamu_top dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .processor_status_word_sp_sel_in(sel),
		.req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .src_spec_in(src_spec_in),
		.dst_spec_in(dst_spec_in), .has_src_in(has_src_in), .byte_op_in(byte_op_in), .reg_wr_en_in(reg_wr_en_in),
		.reg_wr_idx_in(wr_idx), .reg_wr_data_in(wr_data), .reg_wr_byte_in(wr_byte), .mem_req_out(mem_req_out),
		.mem_addr_out(mem_addr_out), .mem_rvalid_in(mem_rvalid_in), .mem_rdata_in(mem_rdata_in),
		.res_valid_out(res_valid_out), .res_is_src_out(res_is_src_out), .res_is_reg_out(res_is_reg_out),
		.res_is_imm_out(res_is_imm_out), .res_reg_out(res_reg_out), .res_addr_out(res_addr_out));
	oamu_mem_model mem (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .mem_req_in(mem_req_out),
		.mem_addr_in(mem_addr_out), .lat_in(lat), .mem_rvalid_out(mem_rvalid_in), .mem_rdata_out(mem_rdata_in));
	always @(negedge clk_sys_in) begin
		if (res_valid_out === 1'b1 && nr < 2) begin
			ra[nr] = res_addr_out;
			rs[nr] = res_is_src_out;
			rg[nr] = res_is_reg_out;
			ri[nr] = res_is_imm_out;
			rr[nr] = res_reg_out;
			nr++;
		end
	end
	task finish_test;
		if (failures == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures++;
			finish_test;
		end
	end
	task wr(input logic [2:0] i, input logic [15:0] d, input logic b);
		@(posedge clk_sys_in);
		reg_wr_en_in <= 1'b1;
		wr_idx <= i;
		wr_data <= d;
		wr_byte <= b;
		@(posedge clk_sys_in);
		reg_wr_en_in <= 1'b0;
	endtask : wr
	task op(input logic [5:0] s, input logic [5:0] d, input logic h, input logic b, input int n);
		int t;
		t = 0;
		@(negedge clk_sys_in);
		while (req_ready_out !== 1'b1 && t < 100) begin
			@(negedge clk_sys_in);
			t++;
		end
		nr = 0;
		@(posedge clk_sys_in);
		req_valid_in <= 1'b1;
		src_spec_in <= s;
		dst_spec_in <= d;
		has_src_in <= h;
		byte_op_in <= b;
		@(posedge clk_sys_in);
		req_valid_in <= 1'b0;
		while (nr < n && t < 200) begin
			@(negedge clk_sys_in);
			t++;
		end
		`CHK("count", n, nr)
	endtask : op
	task t_defer;
		wr(3'h1, 16'h0200, 1'b0);
		wr(3'h2, 16'h0300, 1'b0);
		op(6'h09, 6'h1a, 1'b1, 1'b1, 2);
		`CHK("src", 16'h0200, ra[0])
		`CHK("srcflag", 1'b1, rs[0])
		`CHK("dstflag", 1'b0, rs[1])
		`CHK("dst", 16'h0400, ra[1])
		op(6'h00, 6'h0a, 1'b0, 1'b0, 1);
		`CHK("r2", 16'h0302, ra[0])
	endtask : t_defer
	task t_step;
		lat <= 4'h3;
		wr(3'h3, 16'h0500, 1'b0);
		op(6'h00, 6'h2b, 1'b0, 1'b1, 1);
		`CHK("adecdef", 16'h05fe, ra[0])
		op(6'h00, 6'h0b, 1'b0, 1'b0, 1);
		`CHK("r3", 16'h04fe, ra[0])
		wr(3'h4, 16'h0600, 1'b0);
		op(6'h14, 6'h0c, 1'b1, 1'b1, 2);
		`CHK("ainc", 16'h0600, ra[0])
		`CHK("r4", 16'h0601, ra[1])
		wr(3'h6, 16'h0700, 1'b0);
		op(6'h16, 6'h0e, 1'b1, 1'b1, 2);
		`CHK("r6", 16'h0702, ra[1])
		wr(3'h0, 16'h0800, 1'b0);
		op(6'h20, 6'h08, 1'b1, 1'b0, 2);
		`CHK("adec", 16'h07fe, ra[0])
		`CHK("r0", 16'h07fe, ra[1])
	endtask : t_step
	task t_pc;
		lat <= 4'h1;
		wr(3'h7, 16'h1000, 1'b0);
		op(6'h31, 6'h3f, 1'b1, 1'b0, 2);
		`CHK("index", 16'h1300, ra[0])
		`CHK("srcword", 16'h1300, ra[0])
		`CHK("reldef", 16'h2206, ra[1])
		op(6'h17, 6'h1f, 1'b1, 1'b1, 2);
		`CHK("imm", 16'h1004, ra[0])
		`CHK("immflag", 1'b1, ri[0])
		`CHK("abs", 16'h1106, ra[1])
		`CHK("absflag", 1'b0, ri[1])
		`CHK("bytepc", 16'h1106, ra[1])
		op(6'h37, 6'h39, 1'b1, 1'b0, 2);
		`CHK("rel", 16'h2112, ra[0])
		`CHK("idxdef", 16'h140a, ra[1])
		op(6'h00, 6'h0f, 1'b0, 1'b0, 1);
		`CHK("pc", 16'h100c, ra[0])
	endtask : t_pc
	task t_regs;
		op(6'h05, 6'h04, 1'b1, 1'b1, 2);
		`CHK("isreg", 1'b1, rg[0])
		`CHK("reg", 3'h4, rr[1])
		op(6'h00, 6'h03, 1'b0, 1'b0, 1);
		`CHK("dstreg", 3'h3, rr[0])
		`CHK("dstisreg", 1'b1, rg[0])
		`CHK("dstidx", 16'h0003, ra[0])
		wr(3'h5, 16'h1234, 1'b0);
		wr(3'h5, 16'h00ab, 1'b1);
		op(6'h00, 6'h0d, 1'b0, 1'b0, 1);
		`CHK("lowbyte", 16'h12ab, ra[0])
		@(posedge clk_sys_in);
		sel <= 1'b1;
		wr(3'h6, 16'h0a00, 1'b0);
		sel <= 1'b0;
		op(6'h00, 6'h0e, 1'b0, 1'b0, 1);
		`CHK("sp0", 16'h0702, ra[0])
		@(posedge clk_sys_in);
		sel <= 1'b1;
		op(6'h00, 6'h0e, 1'b0, 1'b0, 1);
		`CHK("sp1", 16'h0a00, ra[0])
	endtask : t_regs
	initial begin
		repeat (20) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		t_defer;
		t_step;
		t_pc;
		t_regs;
		finish_test;
	end
endmodule : oamu_top_tb
`default_nettype wire
